// ### rtl/aapc_pkg.sv
package aapc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] FMT_REG_ADDR = 7'h0B;
    localparam logic [6:0] FLT_REG_ADDR = 7'h0C;
    localparam logic [8:0] FMT_RESET    = 9'h040;
    localparam logic [8:0] FLT_RESET    = 9'h000;
    localparam int FMT_LSB  = 0;
    localparam int WL_LSB   = 2;
    localparam int MS_BIT   = 4;
    localparam int RATE_LSB = 5;
    localparam int OSR_BIT  = 8;
    localparam int HPD_BIT  = 3;
    localparam int LRP_BIT  = 4;
    localparam int BCP_BIT  = 5;
    localparam int MUTE_DEC_OFF_BIT = 6;
    localparam int SYNC_BIT = 7;
    // ------------------------------------------------------------
    // encodings and counts
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FMT_RJ, FMT_LJ, FMT_I2S, FMT_DSP} aapc_fmt_t;
    localparam logic [2:0] RATE_256 = 3'h2;
    localparam logic [2:0] RATE_384 = 3'h3;
    localparam logic [2:0] RATE_512 = 3'h4;
    localparam logic [2:0] RATE_768 = 3'h5;
    localparam logic [3:0] HALF_256 = 4'h2;
    localparam logic [3:0] HALF_384 = 4'h3;
    localparam logic [3:0] HALF_512 = 4'h4;
    localparam logic [3:0] HALF_768 = 4'h6;
    localparam logic [10:0] MIDRAIL_LIMIT = 11'h400;
    localparam logic [5:0] SLOT_BITS    = 6'h20;
    localparam int SAMPLE_W   = 32;
    localparam int PAIR_W     = 64;
    localparam int FIFO_DEPTH = 8;
endpackage

// ### rtl/aapc_top.sv
module aapc_fifo #(
    parameter int W = 64,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } aapc_fifo_state_t;
    aapc_fifo_state_t st_reg, st_next;
    logic [AW:0] used;

    assign used      = st_reg.wp - st_reg.rp;
    assign in_ready  = (used != (AW+1)'(D));
    assign out_valid = (st_reg.wp != st_reg.rp);
    assign out_data  = st_reg.mem[st_reg.rp[AW-1:0]];

    always_comb begin
        st_next = st_reg;
        if (in_valid && in_ready) begin
            st_next.mem[st_reg.wp[AW-1:0]] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

module aapc_top (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  adc_master_clock,
    input  wire logic                  reg_wr_en,
    input  wire logic [6:0]            reg_wr_addr,
    input  wire logic [8:0]            reg_wr_data,
    output logic [8:0]                 fmt_reg_value,
    output logic [8:0]                 flt_reg_value,
    input  wire logic                  sample_valid,
    output logic                       sample_ready,
    input  wire logic [63:0]           sample_data,
    input  wire logic                  adc_enable,
    output logic                       hp_filter_enable,
    output logic                       adc_osr_64,
    output logic                       clock_align,
    input  wire logic                  mute_pin_is_output,
    input  wire logic [1:0]            zero_flag_select,
    input  wire logic [2:0]            dac_sample_strobe,
    input  wire logic [2:0]            dac_sample_midrail,
    output logic [2:0]                 soft_mute,
    input  wire logic                  mute_pin_in,
    output logic                       mute_pin_out,
    output logic                       mute_pin_oe_n,
    input  wire logic                  adc_bit_clock_in,
    output logic                       adc_bit_clock_out,
    output logic                       adc_bit_clock_oe_n,
    input  wire logic                  adc_frame_clock_in,
    output logic                       adc_frame_clock_out,
    output logic                       adc_frame_clock_oe_n,
    output logic                       adc_serial_data
);
    // ------------------------------------------------------------
    // control domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0]  fmt;
        logic [8:0]  flt;
        logic        mute_s1;
        logic        mute_s2;
        logic [10:0] zcount;
        logic        zflag;
        logic [2:0]  smute;
        logic [63:0] pair;
        logic        ack_tgl;
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
    } aapc_core_t;
    aapc_core_t cr_reg, cr_next;
    logic        fifo_valid;
    logic [63:0] fifo_data;
    logic        req_edge;
    logic [2:0]  sel_mask;
    logic        pin_level;
    logic [2:0]  rate;
    logic        lk_req_tgl;

    assign req_edge = cr_reg.req_s2 ^ cr_reg.req_seen;
    assign rate     = cr_reg.fmt[aapc_pkg::RATE_LSB +: 3];

    aapc_fifo #(.W(aapc_pkg::PAIR_W), .D(aapc_pkg::FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (fifo_valid),
        .out_ready (req_edge),
        .out_data  (fifo_data)
    );

    always_comb begin
        cr_next = cr_reg;
        cr_next.mute_s1 = mute_pin_in;
        cr_next.mute_s2 = cr_reg.mute_s1;
        cr_next.req_s1  = lk_req_tgl;
        cr_next.req_s2  = cr_reg.req_s1;
        if (reg_wr_en && reg_wr_addr == aapc_pkg::FMT_REG_ADDR) begin
            cr_next.fmt = reg_wr_data;
        end
        if (reg_wr_en && reg_wr_addr == aapc_pkg::FLT_REG_ADDR) begin
            cr_next.flt = reg_wr_data;
        end
        // refill holding pair on each link request
        if (req_edge) begin
            cr_next.req_seen = cr_reg.req_s2;
            cr_next.pair     = fifo_valid ? fifo_data : '0;
            cr_next.ack_tgl  = ~cr_reg.ack_tgl;
        end
        unique case (zero_flag_select)
            2'h0:    sel_mask = 3'h1;
            2'h1:    sel_mask = 3'h2;
            2'h2:    sel_mask = 3'h4;
            2'h3:    sel_mask = 3'h7;
        endcase
        // midrail run length on the selected DACs
        if (|(dac_sample_strobe & sel_mask)) begin
            if (&(dac_sample_midrail | ~sel_mask)) begin
                if (cr_reg.zcount <= aapc_pkg::MIDRAIL_LIMIT) begin
                    cr_next.zcount = cr_reg.zcount + 11'h001;
                end
            end else begin
                cr_next.zcount = '0;
            end
        end
        cr_next.zflag = (cr_next.zcount > aapc_pkg::MIDRAIL_LIMIT);
        pin_level = mute_pin_is_output ? cr_reg.zflag : cr_reg.mute_s2;
        if (!pin_level) begin
            cr_next.smute = 3'h0;
        end else if (cr_reg.flt[aapc_pkg::MUTE_DEC_OFF_BIT]) begin
            cr_next.smute = 3'h7;
        end else begin
            cr_next.smute = sel_mask;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cr_reg     <= '0;
            cr_reg.fmt <= aapc_pkg::FMT_RESET;
            cr_reg.flt <= aapc_pkg::FLT_RESET;
        end else begin
            cr_reg <= cr_next;
        end
    end

    assign fmt_reg_value    = cr_reg.fmt;
    assign flt_reg_value    = cr_reg.flt;
    assign hp_filter_enable = ~cr_reg.flt[aapc_pkg::HPD_BIT];
    assign adc_osr_64       = cr_reg.fmt[aapc_pkg::OSR_BIT] &&
                              (rate == aapc_pkg::RATE_256 || rate == aapc_pkg::RATE_384);
    assign clock_align      = cr_reg.flt[aapc_pkg::SYNC_BIT];
    assign soft_mute        = cr_reg.smute;
    assign mute_pin_out     = cr_reg.zflag;
    assign mute_pin_oe_n    = ~mute_pin_is_output;

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic [17:0] cfg_s1;
        logic [17:0] cfg_s2;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_seen;
        logic        req_tgl;
        logic        bck_s1;
        logic        bck_s2;
        logic        bck_prev;
        logic        lr_s1;
        logic        lr_s2;
        logic        lr_prev;
        logic        en_s1;
        logic        en_s2;
        logic [3:0]  div;
        logic        bgen;
        logic [5:0]  pos;
        logic [63:0] cur;
        logic [63:0] nxt;
        logic        sdata;
    } aapc_link_t;
    aapc_link_t lk_reg, lk_next;
    logic       master;
    logic       inv_b;
    logic       lrp;
    logic       dsp;
    logic       left_lvl;
    logic       fall_evt;
    logic       lr_eff;
    logic [3:0] half;
    logic [5:0] pos_n;
    logic [5:0] wl;
    aapc_pkg::aapc_fmt_t fmt;

    assign lk_req_tgl = lk_reg.req_tgl;
    assign master     = lk_reg.cfg_s2[aapc_pkg::MS_BIT];
    assign fmt        = aapc_pkg::aapc_fmt_t'(lk_reg.cfg_s2[aapc_pkg::FMT_LSB +: 2]);
    assign dsp        = (fmt == aapc_pkg::FMT_DSP);
    assign lrp        = lk_reg.cfg_s2[9 + aapc_pkg::LRP_BIT];
    assign inv_b      = lk_reg.cfg_s2[9 + aapc_pkg::BCP_BIT];
    assign left_lvl   = (fmt != aapc_pkg::FMT_I2S);
    // inverted frame level swaps channels, outside DSP format only
    assign lr_eff     = lk_reg.lr_s2 ^ (lrp & ~dsp);

    always_comb begin
        int q;
        int k;
        logic [31:0] w;
        q = 0;
        k = 0;
        w = '0;
        lk_next = lk_reg;
        lk_next.cfg_s1 = {cr_reg.flt, cr_reg.fmt};
        lk_next.cfg_s2 = lk_reg.cfg_s1;
        lk_next.ack_s1 = cr_reg.ack_tgl;
        lk_next.ack_s2 = lk_reg.ack_s1;
        lk_next.bck_s1 = adc_bit_clock_in;
        lk_next.bck_s2 = lk_reg.bck_s1;
        lk_next.bck_prev = lk_reg.bck_s2;
        lk_next.lr_s1  = adc_frame_clock_in;
        lk_next.lr_s2  = lk_reg.lr_s1;
        lk_next.en_s1  = adc_enable;
        lk_next.en_s2  = lk_reg.en_s1;
        unique case (lk_reg.cfg_s2[aapc_pkg::RATE_LSB +: 3])
            aapc_pkg::RATE_384: half = aapc_pkg::HALF_384;
            aapc_pkg::RATE_512: half = aapc_pkg::HALF_512;
            aapc_pkg::RATE_768: half = aapc_pkg::HALF_768;
            default:            half = aapc_pkg::HALF_256;
        endcase
        unique case (lk_reg.cfg_s2[aapc_pkg::WL_LSB +: 2])
            2'h0: wl = 6'd16;
            2'h1: wl = 6'd20;
            2'h2: wl = 6'd24;
            2'h3: wl = 6'd32;
        endcase
        fall_evt = 1'b0;
        if (!master || !lk_reg.en_s2) begin
            lk_next.div  = '0;
            lk_next.bgen = 1'b0;
            // normal polarity: the other side changes on falling edge
            fall_evt = ~(lk_reg.bck_s2 ^ inv_b) & (lk_reg.bck_prev ^ inv_b);
        // ratio change may leave div above the new limit
        end else if (lk_reg.div >= half - 4'h1) begin
            lk_next.div  = '0;
            lk_next.bgen = ~lk_reg.bgen;
            fall_evt     = lk_reg.bgen;
        end else begin
            lk_next.div = lk_reg.div + 4'h1;
        end
        pos_n = lk_reg.pos + 6'h01;
        if (!master && fall_evt) begin
            lk_next.lr_prev = lr_eff;
            if (dsp ? (lr_eff & ~lk_reg.lr_prev)
                    : (lr_eff != lk_reg.lr_prev && lr_eff == left_lvl)) begin
                pos_n = '0;
            end
        end
        if (lk_reg.ack_s2 != lk_reg.ack_seen) begin
            lk_next.ack_seen = lk_reg.ack_s2;
            lk_next.nxt      = cr_reg.pair;
        end
        if (fall_evt) begin
            lk_next.pos = pos_n;
            if (pos_n == '0) begin
                lk_next.cur     = lk_reg.nxt;
                lk_next.req_tgl = ~lk_reg.req_tgl;
            end
            if (dsp) begin
                q = int'(pos_n) - (lrp ? 0 : 1);
                w = (q >= int'(wl)) ? lk_next.cur[31:0] : lk_next.cur[63:32];
                k = (q >= int'(wl)) ? q - int'(wl) : q;
                if (q >= 2 * int'(wl)) begin
                    k = -1;
                end
            end else begin
                w = pos_n[5] ? lk_next.cur[31:0] : lk_next.cur[63:32];
                q = int'(pos_n[4:0]);
                unique case (fmt)
                    aapc_pkg::FMT_LJ:  k = q;
                    aapc_pkg::FMT_I2S: k = q - 1;
                    default: k = q - (int'(aapc_pkg::SLOT_BITS) - int'(wl));
                endcase
            end
            // two's complement sample, MSB first
            lk_next.sdata = (k >= 0 && k < int'(wl)) ? w[5'(31 - k)] : 1'b0;
        end
    end

    always_ff @(posedge adc_master_clock or negedge reset_n) begin
        if (!reset_n) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    assign adc_bit_clock_out    = lk_reg.bgen ^ inv_b;
    assign adc_bit_clock_oe_n   = ~master;
    assign adc_frame_clock_oe_n = ~master;
    assign adc_frame_clock_out  = dsp ? (lk_reg.pos == '0)
                                      : ((lk_reg.pos[5] ? ~left_lvl : left_lvl) ^ lrp);
    assign adc_serial_data      = lk_reg.sdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence bgen_high_2;
        lk_reg.bgen [*2] ##1 !lk_reg.bgen;
    endsequence

    AST_HPF_BYPASS: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr_en && reg_wr_addr == aapc_pkg::FLT_REG_ADDR && reg_wr_data[3]
        |=> !hp_filter_enable) else $error("highpass not bypassed");
    AST_OSR_RATE: assert property (@(posedge clk) disable iff (!reset_n)
        adc_osr_64 |-> cr_reg.fmt[8] && rate inside {3'h2, 3'h3})
        else $error("64fs outside 256/384fs");
    AST_MUTE_ALL: assert property (@(posedge clk) disable iff (!reset_n)
        cr_reg.flt[6] && !mute_pin_is_output && cr_reg.mute_s2 |=> soft_mute == 3'h7)
        else $error("decode disabled high pin did not mute all");
    AST_MUTE_SEL: assert property (@(posedge clk) disable iff (!reset_n)
        !cr_reg.flt[6] && !mute_pin_is_output && cr_reg.mute_s2 && zero_flag_select == 2'h0
        |=> soft_mute == 3'h1) else $error("selected DAC not muted");
    AST_ZERO_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(cr_reg.zflag) |-> $past(cr_reg.zcount) == 11'h400)
        else $error("zero flag not after 1025 midrail samples");
    AST_SYNC_BIT: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr_en && reg_wr_addr == aapc_pkg::FLT_REG_ADDR && reg_wr_data[7]
        |=> clock_align) else $error("clock align not set");
    AST_MASTER_DRIVE: assert property (@(posedge adc_master_clock) disable iff (!reset_n)
        master |-> !adc_bit_clock_oe_n && !adc_frame_clock_oe_n)
        else $error("master mode clocks not driven");
    AST_BCLK_256: assert property (@(posedge adc_master_clock) disable iff (!reset_n)
        master && lk_reg.en_s2 && lk_reg.cfg_s2[7:5] == 3'h2 && $rose(lk_reg.bgen)
        && $stable(lk_reg.cfg_s2) |-> bgen_high_2) else $error("bit clock half period wrong");
    AST_DATA_ON_FALL: assert property (@(posedge adc_master_clock) disable iff (!reset_n)
        $changed(lk_reg.sdata) |-> $past(fall_evt)) else $error("data changed off falling edge");
    AST_LR_POLARITY: assert property (@(posedge adc_master_clock) disable iff (!reset_n)
        master && fmt == aapc_pkg::FMT_LJ && lk_reg.pos < 6'h20 |-> adc_frame_clock_out == ~lrp)
        else $error("frame clock polarity wrong");
endmodule

// ### testbench/aapc_dsp_model.sv
module aapc_dsp_model (
    input  wire logic   gen,
    input  wire logic   inv,
    input  wire logic   left_lvl,
    input  wire logic   bclk,
    input  wire logic   frame,
    input  wire logic   sdata,
    output logic        bclk_drv,
    output logic        frame_drv,
    output logic [63:0] got,
    output logic        got_stb
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [63:0] shift_reg;
    logic        prev_frame;
    int          bit_cnt;
    int          launch_cnt;

    // --------
    // capture: one whole 64-bit frame per strobe
    // --------
    initial begin
        got_stb = 1'b0;
        got = 64'h0;
        prev_frame = 1'b0;
        bit_cnt = 0;
        shift_reg = 64'h0;
    end

    always @(posedge bclk or negedge bclk) begin
        if (bclk ^ inv) begin
            if (frame === left_lvl && prev_frame !== left_lvl) begin
                if (bit_cnt == 64) begin
                    got <= shift_reg;
                    got_stb <= ~got_stb;
                end
                shift_reg <= {63'h0, sdata};
                bit_cnt <= 1;
            end else begin
                shift_reg <= {shift_reg[62:0], sdata};
                bit_cnt <= bit_cnt + 1;
            end
            prev_frame <= frame;
        end
    end

    // --------
    // slave clocks, 120 ns bit period, still while gen is low
    // --------
    initial begin
        bclk_drv = 1'b0;
        frame_drv = 1'b0;
        launch_cnt = 0;
        forever begin
            #60;
            if (gen) begin
                bclk_drv = ~bclk_drv;
                if (bclk_drv == inv) begin
                    launch_cnt = launch_cnt + 1;
                    if (launch_cnt % 32 == 0) frame_drv = ~frame_drv;
                end
            end
        end
    end
endmodule

// ### testbench/aapc_top_test.sv
module aapc_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, reset_n, mclk, adc_enable, reg_wr_en;
    logic [6:0]  reg_wr_addr;
    logic [8:0]  reg_wr_data, fmt_reg_value, flt_reg_value;
    logic        sample_valid, sample_ready, hp_filter_enable, adc_osr_64, clock_align;
    logic [63:0] sample_data, got;
    logic        mute_pin_is_output, mute_drv, mute_out, mute_oe_n, mute_w;
    logic [1:0]  zero_flag_select;
    logic [2:0]  dac_sample_strobe, dac_sample_midrail, soft_mute;
    logic        bclk_out, bclk_oe_n, frame_out, frame_oe_n, sdata, bclk_w, frame_w;
    logic        p_bclk, p_frame, gen, inv, lvl, got_stb, ok;
    int          err_count, compares, n;
    int          ratio[4] = '{256, 384, 512, 768};
    realtime     t1;

    assign bclk_w = bclk_oe_n ? p_bclk : bclk_out;
    assign frame_w = frame_oe_n ? p_frame : frame_out;
    assign mute_w = mute_oe_n ? mute_drv : mute_out;

    aapc_top dut (.clk(clk), .reset_n(reset_n), .adc_master_clock(mclk),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .fmt_reg_value(fmt_reg_value), .flt_reg_value(flt_reg_value),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
        .adc_enable(adc_enable), .hp_filter_enable(hp_filter_enable),
        .adc_osr_64(adc_osr_64), .clock_align(clock_align),
        .mute_pin_is_output(mute_pin_is_output), .zero_flag_select(zero_flag_select),
        .dac_sample_strobe(dac_sample_strobe), .dac_sample_midrail(dac_sample_midrail),
        .soft_mute(soft_mute), .mute_pin_in(mute_w), .mute_pin_out(mute_out),
        .mute_pin_oe_n(mute_oe_n), .adc_bit_clock_in(bclk_w), .adc_bit_clock_out(bclk_out),
        .adc_bit_clock_oe_n(bclk_oe_n), .adc_frame_clock_in(frame_w),
        .adc_frame_clock_out(frame_out), .adc_frame_clock_oe_n(frame_oe_n),
        .adc_serial_data(sdata));

    aapc_dsp_model model (.gen(gen), .inv(inv), .left_lvl(lvl), .bclk(bclk_w),
        .frame(frame_w), .sdata(sdata), .bclk_drv(p_bclk), .frame_drv(p_frame),
        .got(got), .got_stb(got_stb));

    // --------
    // clocks and watchdog
    // --------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        mclk = 1'b0;
        #3.2;
        forever #7.5 mclk = ~mclk;
    end
    initial begin
        #2000000;
        err_count++;
        tally_and_finish();
    end

    // --------
    // tasks
    // --------
    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        reg_wr_en <= 1'b1;
        reg_wr_addr <= a;
        reg_wr_data <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        @(posedge clk);
    endtask

    // valid stays high on return; caller lowers it
    task automatic push(input logic [63:0] d, input int lim, output logic acc);
        acc = 1'b0;
        sample_valid <= 1'b1;
        sample_data <= d;
        for (int i = 0; i < lim && !acc; i++) begin
            @(posedge clk);
            acc = (sample_ready === 1'b1);
        end
    endtask

    // s: leading slot bits not carrying the pair
    task automatic expect_pair(input logic [63:0] e, input int s);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 12 && !hit; i++) begin
            @(got_stb);
            hit = ((got << s) === ((e >> s) << s));
        end
        chk(got << s, (e >> s) << s, "frame");
        @(posedge clk);
    endtask

    task automatic run_case(input logic [1:0] f, input logic lrp, input logic bcp,
                            input logic lv, input logic ms, input int s,
                            input logic [63:0] p);
        wr(aapc_pkg::FMT_REG_ADDR, {1'b0, aapc_pkg::RATE_256, ms, 2'h3, f});
        wr(aapc_pkg::FLT_REG_ADDR, {3'h0, bcp, lrp, 4'h0});
        inv <= bcp;
        lvl <= lv;
        gen <= ~ms;
        idle(400);
        chk({bclk_oe_n, frame_oe_n}, {2{~ms}}, "pin dir");
        push(p, 50, ok);
        sample_valid <= 1'b0;
        expect_pair(p, s);
    endtask

    task automatic strobe();
        dac_sample_strobe <= 3'h1;
        @(posedge clk);
        dac_sample_strobe <= 3'h0;
        @(posedge clk);
    endtask

    // --------
    // main sequence
    // --------
    initial begin
        reset_n = 1'b0;
        adc_enable = 1'b1;
        reg_wr_en = 1'b0;
        reg_wr_addr = 7'h00;
        reg_wr_data = 9'h000;
        sample_valid = 1'b0;
        sample_data = 64'h0;
        mute_pin_is_output = 1'b0;
        mute_drv = 1'b0;
        zero_flag_select = 2'h0;
        dac_sample_strobe = 3'h0;
        dac_sample_midrail = 3'h0;
        gen = 1'b0;
        inv = 1'b0;
        lvl = 1'b1;
        err_count = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk(fmt_reg_value, aapc_pkg::FMT_RESET, "fmt reset");
        chk(flt_reg_value, aapc_pkg::FLT_RESET, "flt reset");
        chk({hp_filter_enable, bclk_oe_n, frame_oe_n}, 3'h7, "reset outs");
        wr(aapc_pkg::FLT_REG_ADDR, 9'h008);
        chk({flt_reg_value, hp_filter_enable}, {9'h008, 1'b0}, "hp bypass");
        wr(aapc_pkg::FLT_REG_ADDR, 9'h080);
        chk({clock_align, hp_filter_enable}, 2'h3, "align");
        wr(7'h0D, 9'h1FF);
        chk({fmt_reg_value, flt_reg_value}, {aapc_pkg::FMT_RESET, 9'h080}, "unmapped");
        for (int r = 2; r < 6; r++) begin
            wr(aapc_pkg::FMT_REG_ADDR, {1'b1, 3'(r), 5'h00});
            chk(adc_osr_64, 64'(r < 4), "osr");
        end
        wr(aapc_pkg::FMT_REG_ADDR, {1'b0, aapc_pkg::RATE_256, 5'h00});
        chk(adc_osr_64, 64'h0, "osr off");
        for (int i = 0; i < 4; i++) begin
            wr(aapc_pkg::FMT_REG_ADDR, {1'b0, 3'(i + 2), 5'h1D});
            idle(50);
            @(posedge bclk_out);
            t1 = $realtime;
            @(posedge bclk_out);
            chk(64'(longint'($realtime - t1)), 64'(ratio[i] / 64 * 15), "bclk");
            @(posedge clk);
        end
        run_case(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 0, 64'h8123_4567_89AB_CDEF);
        run_case(2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 0, 64'hF00D_1234_8BAD_5678);
        run_case(2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1, 64'hC3A5_0F1E_8765_4321);
        run_case(2'h3, 1'b0, 1'b0, 1'b1, 1'b1, 1, 64'h9E37_79B9_7F4A_7C15);
        run_case(2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 0, 64'hB504_F333_F9DE_6484);
        run_case(2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 0, 64'hDEAD_BEEF_0123_4567);
        n = 0;
        ok = 1'b1;
        while (ok && n < 12) begin
            push(64'hA000_0001_5000_0002 + 64'(n), 1, ok);
            if (ok) n++;
        end
        sample_valid <= 1'b0;
        chk(64'(n >= aapc_pkg::FIFO_DEPTH && n <= aapc_pkg::FIFO_DEPTH + 1), 64'h1, "fill");
        for (int i = 0; i < n; i++) expect_pair(64'hA000_0001_5000_0002 + 64'(i), 0);
        @(got_stb);
        chk(got, 64'h0, "empty pair");
        @(posedge clk);
        wr(aapc_pkg::FLT_REG_ADDR, 9'h000);
        mute_drv <= 1'b1;
        for (int z = 0; z < 4; z++) begin
            zero_flag_select <= 2'(z);
            idle(6);
            chk(soft_mute, (z == 3) ? 3'h7 : 3'(1 << z), "decode mute");
        end
        wr(aapc_pkg::FLT_REG_ADDR, 9'h040);
        zero_flag_select <= 2'h0;
        idle(6);
        chk(soft_mute, 3'h7, "decode off");
        mute_drv <= 1'b0;
        wr(aapc_pkg::FLT_REG_ADDR, 9'h000);
        mute_pin_is_output <= 1'b1;
        dac_sample_midrail <= 3'h1;
        for (int i = 0; i < 1024; i++) strobe();
        idle(4);
        chk({mute_out, mute_oe_n}, 2'h0, "1024 midrail");
        strobe();
        idle(4);
        chk({mute_out, soft_mute[0]}, 2'h3, "1025 midrail");
        dac_sample_midrail <= 3'h0;
        strobe();
        idle(4);
        chk(mute_out, 64'h0, "midrail clear");
        tally_and_finish();
    end
endmodule
